// ===== hdl/smcp_chan.sv
/*
  One serial channel's modem and line control pin logic, behind APB.
  Assumes the transmitter, receiver and receive FIFO of the channel supply
  status levels on this clock; pins and link clocks are asynchronous.
*/
`timescale 1ns/1ps
module smcp_chan (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Channel status from transmitter, receiver and FIFO
  input wire logic tx_busy_i,
  input wire logic tx_pending_i,
  input wire logic tx_frame_i,
  input wire logic tx_coll_bit_i,
  input wire logic rx_frame_i,
  input wire logic fifo_shadow_empty_i,
  input wire logic fifo_thresh_i,
  input wire logic tx_data_i,
  // Asynchronous pins
  input wire logic clear_to_send_n_i,
  input wire logic carrier_detect_in_i,
  input wire logic rx_clock_pin_i,
  input wire logic tx_clock_pin_i,
  input wire logic oscillator_clock_in_i,
  // Request pin and transmit data pin
  output logic request_n_o,
  output logic txd_o,
  output logic txd_oe_o,
  // Derived controls to the channel
  output logic tx_enable_o,
  output logic rx_enable_o,
  output logic rx_strobe_o,
  output logic frame_sync_o,
  output logic tx_gate_o,
  output logic rx_gate_o,
  output logic rx_clk_tick_o,
  output logic tx_clk_tick_o,
  output logic brg_clk_tick_o,
  output logic ref_clk_tick_o,
  output logic collision_o,
  output logic event_o
);
  // Configuration and event registers
  logic [31:0] cfg_q;
  logic [2:0] evt_q;
  logic [2:0] evt_d;
  // Synchronisers: stage one read only by stage two
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic [4:0] s3_q;
  // Delayed transmit frame for the one clock shift
  logic txf_dly_q;
  logic rts_q;
  logic rts_d;
  logic [31:0] rd_d;
  // Field decode
  wire [2:0] cmode = cfg_q[smcp_pkg::SMCP_CM_MSB:smcp_pkg::SMCP_CM_LSB];
  wire [2:0] rtsm_raw = cfg_q[smcp_pkg::SMCP_RTSM_MSB:smcp_pkg::SMCP_RTSM_LSB];
  wire rts_bit = cfg_q[smcp_pkg::SMCP_RTS_BIT];
  wire tx_clock_out_enable = cfg_q[smcp_pkg::SMCP_TX_CLOCK_OUT_ENABLE_BIT];
  wire bus_cfg = cfg_q[smcp_pkg::SMCP_BUS_BIT];
  wire async_cfg = cfg_q[smcp_pkg::SMCP_ASYNC_BIT];
  wire astart = cfg_q[smcp_pkg::SMCP_ASTART_BIT];
  wire osc_sel = cfg_q[smcp_pkg::SMCP_OSC_BIT];
  wire host_lvl = cfg_q[smcp_pkg::SMCP_HOSTLVL_BIT];
  // Synchronised pins
  wire cts_n = s2_q[0];
  wire cd = s2_q[1];
  wire rxc = s2_q[2];
  wire txc = s2_q[3];
  wire osc = s2_q[4];
  wire [4:0] rise = s2_q & ~s3_q;
  // Clock mode decode
  wire cm0 = (cmode == 3'd0);
  wire cm1 = (cmode == 3'd1);
  wire cm4 = (cmode == 3'd4);
  wire cm5 = (cmode == 3'd5);
  wire cd_modem = cmode inside {3'd0, 3'd2, 3'd3, 3'd6, 3'd7};
  // Baud generator modes, read by the tick checks
  wire cm_brg = (cmode == 3'd2) | (cmode == 3'd3);
  // Request mode decode for the checks below
  wire plain_cfg = ~bus_cfg & ~async_cfg;
  wire bus_tx = bus_cfg & (rtsm_raw == smcp_pkg::SMCP_RM_BUSTX);
  wire asy_only = async_cfg & ~bus_cfg;
  wire asy_auto = asy_only & (rtsm_raw == smcp_pkg::SMCP_RM_AUTO);
  wire asy_flow = asy_only & (rtsm_raw == smcp_pkg::SMCP_RM_FLOW);
  wire asy_host = asy_only & (rtsm_raw == smcp_pkg::SMCP_RM_HOST);
  // Bus access decode
  wire acc = psel_i & penable_i;
  wire wr_cfg = acc & pwrite_i & (paddr_i == smcp_pkg::SMCP_CFG_OFF);
  wire wr_evt = acc & pwrite_i & (paddr_i == smcp_pkg::SMCP_EVT_OFF);
  wire mapped = (paddr_i == smcp_pkg::SMCP_CFG_OFF) |
                (paddr_i == smcp_pkg::SMCP_STAT_OFF) |
                (paddr_i == smcp_pkg::SMCP_EVT_OFF);
  // Collision: driving one while line senses zero
  wire coll = bus_cfg & txd_o & ~cts_n;
  // Pin change events
  wire cts_chg = cfg_q[smcp_pkg::SMCP_CTSIE_BIT] & (s2_q[0] ^ s3_q[0]);
  wire cd_chg = cfg_q[smcp_pkg::SMCP_CDIE_BIT] & (s2_q[1] ^ s3_q[1]);
  wire [2:0] evt_set = {coll, cd_chg, cts_chg};

  // Zero-wait APB slave; unmapped addresses flag an error
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~mapped;
  assign event_o = |evt_q;
  assign collision_o = coll;

  // Transmitter runs only while clear is low; mode 4 reuses the pin as gate
  assign tx_enable_o = ~cm4 & ~cts_n;
  assign tx_gate_o = cm4 & ~cts_n;
  // Carrier pin roles by clock mode
  assign rx_enable_o = (cd_modem & astart) ? cd : 1'b1;
  assign rx_strobe_o = cm1 & cd;
  assign frame_sync_o = cm5 & cd;
  assign rx_gate_o = cm4 & cd;
  // Receive clock pin role per clock mode
  assign rx_clk_tick_o = (cm0 | cm4 | cm1 | cm5) & rise[2];
  assign tx_clk_tick_o = (cm1 | cm5) ? rise[2] : rise[3];
  assign brg_clk_tick_o = cmode inside {3'd2, 3'd3} ? rise[2] : 1'b0;
  // Oscillator pin as reference clock in modes 0b, 6, 7
  assign ref_clk_tick_o = osc_sel & (cm0 | (cmode inside {3'd6, 3'd7})) & rise[4];
  // Transmit data: open drain in bus configuration
  assign txd_o = tx_data_i;
  assign txd_oe_o = bus_cfg ? ~tx_data_i : 1'b1;
  // Request pin: transmit clock in mode 4, always actively driven
  assign request_n_o = (cm4 & tx_clock_out_enable) ? txc : rts_q;
  // Read mux
  assign rd_d = (paddr_i == smcp_pkg::SMCP_CFG_OFF) ? cfg_q :
                (paddr_i == smcp_pkg::SMCP_STAT_OFF) ?
                  {24'h00_0000, coll, cts_n, cd, rxc, txc, osc, rts_q, tx_busy_i} :
                (paddr_i == smcp_pkg::SMCP_EVT_OFF) ? {29'h0000_0000, evt_q} :
                32'h0000_0000;
  assign prdata_o = rd_d;

  // Request level selection
  always_comb begin
    rts_d = rts_q;
    if (bus_cfg) begin
      case (smcp_pkg::smcp_rtsm_t'(rtsm_raw))
        smcp_pkg::SMCP_RM_BUSTX: rts_d = ~(txf_dly_q & ~tx_coll_bit_i);
        smcp_pkg::SMCP_RM_BUSRX: rts_d = ~rx_frame_i;
        smcp_pkg::SMCP_RM_OFF: rts_d = 1'b1;
        default: rts_d = 1'b1;
      endcase
    end else if (async_cfg) begin
      case (smcp_pkg::smcp_rtsm_t'(rtsm_raw))
        smcp_pkg::SMCP_RM_FLOW: begin
          if (fifo_thresh_i) rts_d = 1'b1;
          else if (fifo_shadow_empty_i) rts_d = 1'b0;
        end
        smcp_pkg::SMCP_RM_HOST: rts_d = host_lvl;
        default: rts_d = ~tx_frame_i;
      endcase
    end else begin
      if (rts_bit) rts_d = 1'b0;
      else if (~tx_busy_i & ~tx_pending_i) rts_d = 1'b1;
    end
  end

  // Event flags: a new event wins over a software clear
  always_comb begin
    evt_d = evt_q;
    if (wr_evt) evt_d = evt_q & ~pwdata_i[2:0];
    evt_d = evt_d | evt_set;
  end

  // Configuration register, private to this channel's instance
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) cfg_q <= smcp_pkg::SMCP_CFG_RST;
    else if (wr_cfg) cfg_q <= pwdata_i & smcp_pkg::SMCP_CFG_MASK;
  end

  // Pin synchronisers and edge history
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_q <= 5'h01;
      s2_q <= 5'h01;
      s3_q <= 5'h01;
    end else begin
      s1_q <= {oscillator_clock_in_i, tx_clock_pin_i, rx_clock_pin_i,
               carrier_detect_in_i, clear_to_send_n_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Request state, delayed frame and events
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rts_q <= 1'b1;
      txf_dly_q <= 1'b0;
      evt_q <= 3'h0;
    end else begin
      rts_q <= rts_d;
      if (rise[3]) txf_dly_q <= tx_frame_i;
      evt_q <= evt_d;
    end
  end

  // Frame seen at a transmit clock edge in bus transmit mode
  sequence tx_frame_s;
    bus_tx & rise[3] & tx_frame_i;
  endsequence
  // Following bit is a plain data bit
  sequence clean_bit_s;
    bus_tx & ~tx_coll_bit_i;
  endsequence

  // Request goes low the cycle after the bit is set in plain mode
  rts_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (plain_cfg & rts_bit) |=> ~rts_q)
    else $error("request not low with bit set");

  // Low request stays low while the transmitter is busy
  rts_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (plain_cfg & ~rts_q & tx_busy_i) |=> ~rts_q)
    else $error("request released while busy");

  // Bit clear, transmitter idle, nothing pending: request released
  rts_free_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (plain_cfg & ~rts_bit & ~tx_busy_i & ~tx_pending_i) |=> rts_q)
    else $error("request not released when idle");

  // Disabled bus request never goes low
  rts_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (bus_cfg & (rtsm_raw == 3'b011)) ##1 (bus_cfg & (rtsm_raw == 3'b011)) |-> rts_q)
    else $error("disabled request driven low");

  // Reception in bus receive mode pulls request low
  rts_rx_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (bus_cfg & (rtsm_raw == 3'b010) & rx_frame_i) |=> ~rts_q)
    else $error("request not low in reception");

  // Frame bit one transmit clock late pulls request low
  rts_frame_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (tx_frame_s ##1 clean_bit_s) |=> ~rts_q)
    else $error("request not low during frame");

  // Collision bits never drive the request
  rts_coll_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (bus_tx & tx_coll_bit_i) |=> rts_q)
    else $error("request low on collision bit");

  // No frame at the clock edge: request high
  rts_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ((bus_tx & rise[3] & ~tx_frame_i) ##1 bus_tx) |=> rts_q)
    else $error("request low without frame");

  // Async default: low while a frame is sent
  rts_auto_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (asy_auto & tx_frame_i) |=> ~rts_q)
    else $error("request not low in async frame");

  // Async default: high once the frame is done
  rts_done_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (asy_auto & ~tx_frame_i) |=> rts_q)
    else $error("request low after async frame");

  // Flow control: threshold forces inactive
  rts_flow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (asy_flow & fifo_thresh_i) |=> rts_q)
    else $error("request active at threshold");

  // Flow control: empty shadow forces active
  rts_empty_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (asy_flow & ~fifo_thresh_i & fifo_shadow_empty_i) |=> ~rts_q)
    else $error("request inactive on empty shadow");

  // Host option: pin follows the host level bit
  rts_host_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    asy_host |=> (rts_q == $past(host_lvl)))
    else $error("request not at host level");

  // Without the clock option the pin shows the request level
  rts_push_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cm4 & ~tx_clock_out_enable) |-> (request_n_o == rts_q))
    else $error("request pin not driven");

  // Transmitter held off while clear is high
  txen_cts_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_enable_o |-> ~cts_n)
    else $error("transmitter enabled without clear");

  // Clear pin change sets its event flag
  cts_evt_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cts_chg & ~wr_evt) |=> evt_q[smcp_pkg::SMCP_EV_CTS])
    else $error("clear change not flagged");

  // Event flags stay set until written
  evt_keep_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (~wr_evt & (|evt_q)) |=> ((evt_q & $past(evt_q)) == $past(evt_q)))
    else $error("event flag lost");

  // Line low while driving one flags a collision
  coll_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (bus_cfg & txd_o & ~cts_n) |=> evt_q[smcp_pkg::SMCP_EV_COLL])
    else $error("collision not flagged");

  // Clear pin acts as transmit gate in mode 4 only
  tx_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_gate_o |-> (cm4 & ~cts_n))
    else $error("transmit gate outside mode 4");

  // Mode 4 never enables the plain transmitter path
  tx_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cm4 |-> ~tx_enable_o)
    else $error("transmitter enabled in mode 4");

  // Auto-start: receiver follows the carrier
  rx_en_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cd_modem & astart) |-> (rx_enable_o == cd))
    else $error("receiver not following carrier");

  // Carrier as receive strobe only in mode 1
  rx_strb_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_strobe_o |-> (cm1 & cd))
    else $error("receive strobe outside mode 1");

  // Carrier change sets its event flag
  cd_evt_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cd_chg & ~wr_evt) |=> evt_q[smcp_pkg::SMCP_EV_CD])
    else $error("carrier change not flagged");

  // Carrier as frame sync only in mode 5
  fsync_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    frame_sync_o |-> (cm5 & cd))
    else $error("frame sync outside mode 5");

  // Carrier as receive gate only in mode 4
  rx_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_gate_o |-> (cm4 & cd))
    else $error("receive gate outside mode 4");

  // Oscillator ticks only when selected
  ref_tick_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ref_clk_tick_o |-> osc_sel)
    else $error("reference tick not selected");

  // Baud generator ticks only in modes 2 and 3
  brg_tick_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    brg_clk_tick_o |-> (cm_brg & rise[2]))
    else $error("baud tick in wrong mode");

  // Transmit clock on the request pin in mode 4
  txclk_pin_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cm4 & tx_clock_out_enable) |-> (request_n_o == txc))
    else $error("transmit clock not on pin");
endmodule : smcp_chan

// ===== hdl/smcp_pkg.sv
/*
  Constants for the per-channel modem control pin block: event bits,
  request pin modes, control register offsets, field positions and resets.
  Assumes a 32-bit APB register bus and a 25 MHz system clock.
*/
package smcp_pkg;
  // Register byte offsets
  localparam logic [7:0] SMCP_CFG_OFF = 8'h00;
  localparam logic [7:0] SMCP_STAT_OFF = 8'h04;
  localparam logic [7:0] SMCP_EVT_OFF = 8'h08;
  // Config field positions
  localparam int SMCP_CM_LSB = 0;
  localparam int SMCP_CM_MSB = 2;
  localparam int SMCP_RTSM_LSB = 4;
  localparam int SMCP_RTSM_MSB = 6;
  localparam int SMCP_RTS_BIT = 7;
  localparam int SMCP_TX_CLOCK_OUT_ENABLE_BIT = 8;
  localparam int SMCP_BUS_BIT = 9;
  localparam int SMCP_ASYNC_BIT = 10;
  localparam int SMCP_ASTART_BIT = 11;
  localparam int SMCP_CTSIE_BIT = 12;
  localparam int SMCP_CDIE_BIT = 13;
  localparam int SMCP_OSC_BIT = 14;
  localparam int SMCP_HOSTLVL_BIT = 15;
  localparam logic [31:0] SMCP_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] SMCP_CFG_MASK = 32'h0000_fff7;
  // Event bits
  localparam int SMCP_EV_CTS = 0;
  localparam int SMCP_EV_CD = 1;
  localparam int SMCP_EV_COLL = 2;
  // Request pin modes
  typedef enum logic [2:0] {
    SMCP_RM_SW = 3'b000,    // Software bit with transmit hold-off
    SMCP_RM_BUSTX = 3'b001, // Bus: low while frame sent, one clock late
    SMCP_RM_BUSRX = 3'b010, // Bus: low while frame received
    SMCP_RM_OFF = 3'b011,   // Bus: always high
    SMCP_RM_AUTO = 3'b100,  // Async: low during frame transmission
    SMCP_RM_FLOW = 3'b101,  // Async: receive flow control
    SMCP_RM_HOST = 3'b110   // Async: level set by host
  } smcp_rtsm_t;
endpackage : smcp_pkg

// ===== verification/smcp_chan_tb.sv
/*
  Self-checking bench for one channel's modem control pins.
  Assumes the far-side model and zero-wait APB with pready high.
*/
`timescale 1ns/1ps
module smcp_chan_tb;
  localparam logic [7:0] A_CFG = smcp_pkg::SMCP_CFG_OFF;
  localparam logic [7:0] A_STAT = smcp_pkg::SMCP_STAT_OFF;
  localparam logic [7:0] A_EVT = smcp_pkg::SMCP_EVT_OFF;
  localparam logic [31:0] B_RTS = 32'h1 << smcp_pkg::SMCP_RTS_BIT;
  localparam logic [31:0] B_TX_CLOCK_OUT_ENABLE = 32'h1 << smcp_pkg::SMCP_TX_CLOCK_OUT_ENABLE_BIT;
  localparam logic [31:0] B_BUS = 32'h1 << smcp_pkg::SMCP_BUS_BIT;
  localparam logic [31:0] B_ASY = 32'h1 << smcp_pkg::SMCP_ASYNC_BIT;
  localparam logic [31:0] B_AS = 32'h1 << smcp_pkg::SMCP_ASTART_BIT;
  localparam logic [31:0] B_CIE = 32'h1 << smcp_pkg::SMCP_CTSIE_BIT;
  localparam logic [31:0] B_CDIE = 32'h1 << smcp_pkg::SMCP_CDIE_BIT;
  localparam logic [31:0] B_OSC = 32'h1 << smcp_pkg::SMCP_OSC_BIT;
  localparam logic [31:0] B_HL = 32'h1 << smcp_pkg::SMCP_HOSTLVL_BIT;
  localparam logic [2:0] CMS [5] = '{3'h1, 3'h5, 3'h4, 3'h0, 3'h4};
  // Clock, reset and APB
  logic clk_i = 1'b0, sys_rst = 1'b1, psel = 1'b0, pen = 1'b0, pw = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pd = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  // Channel status and far-side controls
  logic busy = 1'b0, pend = 1'b0, txf = 1'b0, collb = 1'b0, rxf = 1'b0;
  logic she = 1'b0, thr = 1'b0, txdat = 1'b0, cd = 1'b0, ctsl = 1'b1;
  logic bus = 1'b0, jam = 1'b0, run = 1'b0, cts_n, lclk, osc;
  // Design outputs
  logic req_n, txd, txd_oe, txen, rxen, rxs, fs, tg, rg, rxt, txt, brg, reft, coll, evt;
  int mismatches = 0;
  int samples_checked = 0;
  smcp_chan dut (.clk_i(clk_i), .sys_rst_i(sys_rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pw), .paddr_i(pa), .pwdata_i(pd), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .tx_busy_i(busy), .tx_pending_i(pend), .tx_frame_i(txf),
    .tx_coll_bit_i(collb), .rx_frame_i(rxf), .fifo_shadow_empty_i(she),
    .fifo_thresh_i(thr), .tx_data_i(txdat), .clear_to_send_n_i(cts_n),
    .carrier_detect_in_i(cd), .rx_clock_pin_i(lclk), .tx_clock_pin_i(lclk),
    .oscillator_clock_in_i(osc), .request_n_o(req_n), .txd_o(txd), .txd_oe_o(txd_oe),
    .tx_enable_o(txen), .rx_enable_o(rxen), .rx_strobe_o(rxs), .frame_sync_o(fs),
    .tx_gate_o(tg), .rx_gate_o(rg), .rx_clk_tick_o(rxt), .tx_clk_tick_o(txt),
    .brg_clk_tick_o(brg), .ref_clk_tick_o(reft), .collision_o(coll), .event_o(evt));
  smcp_modem_model far (.run_i(run), .cts_lvl_i(ctsl), .bus_i(bus), .jam_i(jam),
    .txd_i(txd), .txd_oe_i(txd_oe), .cts_n_o(cts_n), .link_clk_o(lclk), .osc_o(osc));
  // 25 MHz clock
  always #20 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; waits for pready, takes data at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1; pen <= 1'b0; pw <= w; pa <= a; pd <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) mismatches++;
    rd = prdata; er = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb
  // Settle: pin sync plus request register
  task automatic st;
    repeat (8) @(posedge clk_i);
  endtask : st
  task automatic cfg(input logic [31:0] d);
    apb(1'b1, A_CFG, d);
    st;
  endtask : cfg
  function automatic logic [31:0] rm(input smcp_pkg::smcp_rtsm_t m);
    return 32'(m) << smcp_pkg::SMCP_RTSM_LSB;
  endfunction : rm
  function automatic logic pick(input int k);
    case (k)
      0: return rxs;
      1: return fs;
      2: return rg;
      3: return rxen;
      default: return tg;
    endcase
  endfunction : pick
  // Counts request edges, receive ticks and reference ticks
  task automatic cnt(output int a, output int b, output int c);
    logic p;
    a = 0; b = 0; c = 0; p = req_n;
    repeat (200) begin
      @(posedge clk_i);
      if (req_n !== p) a++;
      p = req_n;
      if (rxt === 1'b1) b++;
      if (reft === 1'b1) c++;
    end
  endtask : cnt
  task automatic t_reset;
    chk(req_n, 1'b1);
    apb(1'b0, A_CFG, 32'h0);
    chk(pready, 1'b1);
    chk(rd, smcp_pkg::SMCP_CFG_RST);
    apb(1'b0, 8'h0c, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, A_CFG, 32'hffff_ffff);
    apb(1'b0, A_CFG, 32'h0);
    chk(rd, smcp_pkg::SMCP_CFG_MASK);
    cfg(32'h0);
    apb(1'b1, A_EVT, 32'hffff_ffff);
  endtask : t_reset
  task automatic t_sw;
    cfg(B_RTS); chk(req_n, 1'b0);
    busy <= 1'b1; cfg(32'h0); chk(req_n, 1'b0);
    busy <= 1'b0; pend <= 1'b1; st; chk(req_n, 1'b0);
    pend <= 1'b0; st; chk(req_n, 1'b1);
  endtask : t_sw
  task automatic t_bus;
    run <= 1'b1; cfg(B_BUS | rm(smcp_pkg::SMCP_RM_BUSTX));
    txf <= 1'b1; st; st; chk(req_n, 1'b0);
    collb <= 1'b1; st; st; chk(req_n, 1'b1);
    collb <= 1'b0; txf <= 1'b0; cfg(B_BUS | rm(smcp_pkg::SMCP_RM_BUSRX));
    rxf <= 1'b1; st; chk(req_n, 1'b0);
    cfg(B_BUS | rm(smcp_pkg::SMCP_RM_OFF)); txf <= 1'b1; st; st; chk(req_n, 1'b1);
    rxf <= 1'b0; txf <= 1'b0; run <= 1'b0;
  endtask : t_bus
  task automatic t_async;
    logic lv;
    cfg(B_ASY | rm(smcp_pkg::SMCP_RM_AUTO)); txf <= 1'b1; st; chk(req_n, 1'b0);
    txf <= 1'b0; st; chk(req_n, 1'b1);
    cfg(B_ASY | rm(smcp_pkg::SMCP_RM_FLOW)); she <= 1'b1; st; chk(req_n, 1'b0);
    she <= 1'b0; thr <= 1'b1; st; chk(req_n, 1'b1);
    thr <= 1'b0; cfg(B_ASY | rm(smcp_pkg::SMCP_RM_HOST)); lv = req_n;
    cfg(B_ASY | rm(smcp_pkg::SMCP_RM_HOST) | B_HL); chk(req_n ^ lv, 1'b1);
  endtask : t_async
  task automatic t_cts;
    cfg(B_CIE); ctsl <= 1'b0; st; chk(txen, 1'b1);
    chk(evt, 1'b1);
    apb(1'b1, A_EVT, 32'h1 << smcp_pkg::SMCP_EV_CTS); apb(1'b0, A_EVT, 32'h0); chk(rd, 32'h0);
    ctsl <= 1'b1; st; chk(txen, 1'b0);
    bus <= 1'b1; cfg(B_BUS); txdat <= 1'b1; jam <= 1'b1; st; chk(coll, 1'b1);
    chk(txd, 1'b1);
    chk(txd_oe, 1'b0);
    txdat <= 1'b0; st; chk(coll, 1'b0);
    apb(1'b0, A_EVT, 32'h0); chk(rd[smcp_pkg::SMCP_EV_COLL], 1'b1);
    jam <= 1'b0; bus <= 1'b0; apb(1'b1, A_EVT, 32'hffff_ffff);
  endtask : t_cts
  task automatic t_modes;
    logic a;
    for (int k = 0; k < 5; k++) begin
      cfg(32'(CMS[k]) | B_CDIE | ((k == 3) ? B_AS : 32'h0));
      if (k == 4) ctsl <= 1'b0; else cd <= 1'b0;
      st; a = pick(k);
      if (k == 4) ctsl <= 1'b1; else cd <= 1'b1;
      st; chk(pick(k) ^ a, 1'b1);
    end
    apb(1'b0, A_EVT, 32'h0); chk(rd[smcp_pkg::SMCP_EV_CD], 1'b1);
    apb(1'b0, A_STAT, 32'h0); chk(rd[5], 1'b1);
    cd <= 1'b0; st; apb(1'b0, A_STAT, 32'h0); chk(rd[5], 1'b0);
  endtask : t_modes
  task automatic t_clk;
    int a, b, c, n, m;
    run <= 1'b1; cfg(32'h4 | B_TX_CLOCK_OUT_ENABLE); cnt(a, b, c);
    chk(a > 20, 1'b1);
    chk(b > 20, 1'b1);
    cfg(32'h2); n = 0; m = 0;
    repeat (200) begin
      @(posedge clk_i);
      if (brg === 1'b1) n++;
      if (txt === 1'b1) m++;
    end
    chk(n > 20, 1'b1);
    chk(m > 20, 1'b1);
    cfg(32'h6 | B_OSC); cnt(a, b, c); chk(c > 20, 1'b1);
    run <= 1'b0; st; cnt(a, b, c); chk(b, 32'h0);
  endtask : t_clk
  task automatic wrap_up;
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // Main sequence after 12 reset cycles
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst <= 1'b0;
    t_reset; t_sw; t_bus; t_async; t_cts; t_modes; t_clk;
    wrap_up;
  end
  // Watchdog well past the expected run
  initial begin
    #1000000;
    mismatches++;
    wrap_up;
  end
endmodule : smcp_chan_tb

// ===== verification/smcp_modem_model.sv
/*
  Far-side model: modem pins, shared open-drain bus and link clocks.
  Assumes the bench sets pin levels and a run flag for frames.
*/
`timescale 1ns/1ps
module smcp_modem_model (
  // Bench controls
  input wire logic run_i,
  input wire logic cts_lvl_i,
  input wire logic bus_i,
  input wire logic jam_i,
  // Device transmit pin
  input wire logic txd_i,
  input wire logic txd_oe_i,
  // Pins toward the device
  output logic cts_n_o,
  output logic link_clk_o,
  output logic osc_o
);
  logic bus_line; // Shared bus, pulled up when released
  initial link_clk_o = 1'b0;
  initial osc_o = 1'b0;
  // Link clock stands still outside frames, 320 ns period
  always #160 if (run_i) link_clk_o = ~link_clk_o;
  // Free-running oscillator
  always #100 osc_o = ~osc_o;
  // Wired bus: device pulls low only when enabled; jam forces low
  assign bus_line = ~((txd_oe_i & ~txd_i) | jam_i);
  // Collision sense shares the clear pin; request pin not looked at
  assign cts_n_o = bus_i ? bus_line : cts_lvl_i;
endmodule : smcp_modem_model
